// [design/psa_crc16.sv]
// ccitt crc16 over payload bytes, preset at packet start
`timescale 1ns/1ns
module psa_crc16 (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        start_i,
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_i,
	output logic      [15:0] crc_o
);
	import psa_pkg::*;

	// one byte through the msb-first ccitt polynomial
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ PSA_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// preset covers only payload, header is never fed in
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || start_i) begin
			crc_o <= PSA_CRC_PRESET;
		end else if (byte_valid_i) begin
			crc_o <= crc_step(crc_o, byte_i);
		end
	end
endmodule

// [design/psa_sched_ack.sv]
// scheduler of due output packets and acknowledgement responder
`timescale 1ns/1ns
// Notes on behaviour
// - due packets go out in ascending id
// - one cycle shares one sampled time
// - time reported via ids 20, 21, 22
// - system packet directions and lengths
// - state packets 20-43 fixed lengths, 31 varies
// - aiding 44-48 read/write with lengths
// - ids 67 and 83 write-only inputs
// - config 180, 181, 182 read/write
// - 190, 193 write-only; 191 read-only
// - ack is id 0, byte0 answered id
// - ack bytes 1-2 received crc, little-endian
// - ack byte 3 result, 0 success
// - result 1 on crc failure
// - result 2 on length mismatch
// - result 3 on out-of-range fields
// - result 4 on flash store failure
// - result 5 when not ready
// - result 6 on unknown identifier
// - crc16 ccitt over payload, preset FFFF
// - every configuration write gets acknowledged; a newer completion replaces an ack not yet sent
// - aiding packets acked only on rejection
module psa_sched_ack (
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	// received payload stream for crc checking
	input  wire logic              rx_start_i,
	input  wire logic              rx_byte_valid_i,
	input  wire logic [7:0]        rx_byte_i,
	// received packet complete, header summary
	input  wire logic              rx_done_i,
	input  wire psa_pkg::psa_rx_s  rx_info_i,
	// schedule: one bit per id due in this output cycle
	input  wire logic              cycle_tick_i,
	input  wire logic [255:0]      due_mask_i,
	input  wire logic [31:0]       time_now_i,
	// transmit side
	input  wire logic              tx_ready_i,
	output psa_pkg::psa_tx_s       tx_hdr_o,
	output logic                   tx_valid_o,
	output logic                   tx_is_ack_o,
	output logic [31:0]            ack_payload_o,
	output logic                   rx_accept_o,
	output logic                   busy_o
);
	import psa_pkg::*;

	// scheduler state
	typedef enum logic [2:0] {
		PSA_IDLE = 3'b001,
		PSA_SCAN = 3'b010,
		PSA_SEND = 3'b100
	} psa_state_e;

	psa_state_e        state;          // scheduler state
	psa_state_e        next_state;
	logic [255:0]      pending;        // ids still to send this cycle
	logic [31:0]       tov;            // latched time of validity
	logic [7:0]        cur_id;         // lowest pending id
	logic              any_pending;
	psa_entry_s        sched_ent;      // table entry for cur_id
	psa_entry_s        rx_ent;         // table entry for received id
	logic [15:0]       crc_calc;       // crc over received payload
	logic              ack_pend;       // acknowledgement waiting
	logic [31:0]       ack_word;       // latched ack payload
	logic [7:0]        result;         // chosen result code
	logic              len_ok;
	logic              is_cfg;
	logic              is_aid;
	logic              want_ack;
	logic              send_ack;       // ack takes the next slot
	logic              send_sched;

	// payload crc, header bytes are never fed here
	psa_crc16 u_crc (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.start_i      (rx_start_i),
		.byte_valid_i (rx_byte_valid_i),
		.byte_i       (rx_byte_i),
		.crc_o        (crc_calc)
	);

	// lookups for the scheduled id and for the received id
	psa_table u_tab_sched (
		.id_i    (cur_id),
		.entry_o (sched_ent)
	);
	psa_table u_tab_rx (
		.id_i    (rx_info_i.id),
		.entry_o (rx_ent)
	);

	// lowest set bit wins; a priority search keeps ascending order
	function automatic logic [7:0] lowest_set(input logic [255:0] m);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 255; i >= 0; i--) begin
			if (m[i]) begin
				r = 8'(i);
			end
		end
		return r;
	endfunction

	assign cur_id      = lowest_set(pending);
	assign any_pending = |pending;

	// length check: fixed, one of two, or variable
	assign len_ok = rx_ent.var_len ||
		(rx_info_i.len == rx_ent.len_a) ||
		((rx_ent.len_b != PSA_LEN_VAR) &&
		 (rx_info_i.len == rx_ent.len_b));

	assign is_cfg = (rx_info_i.id >= PSA_ID_CFG_FIRST);
	assign is_aid = (rx_info_i.id >= PSA_ID_AID_FIRST) &&
		(rx_info_i.id <= PSA_ID_AID_LAST);

	// result priority: unknown, crc, size, ready, range, flash
	assign result =
		(!rx_ent.known || !rx_ent.wr) ? PSA_RES_UNKNOWN :
		(crc_calc != rx_info_i.crc_rx) ? PSA_RES_CRC :
		(!len_ok)             ? PSA_RES_SIZE :
		(rx_info_i.not_ready) ? PSA_RES_NOTRDY :
		(rx_info_i.range_err) ? PSA_RES_RANGE :
		(rx_info_i.flash_err) ? PSA_RES_FLASH :
		PSA_RES_OK;

	// aiding success is silent; config and others always answered
	assign want_ack = (is_cfg || !is_aid) ? 1'b1 :
		(result != PSA_RES_OK);

	// ack has priority for the next free slot, never cuts a packet
	assign send_ack   = ack_pend && (!tx_valid_o || tx_ready_i);
	assign send_sched = !send_ack && (state == PSA_SCAN) &&
		any_pending && (!tx_valid_o || tx_ready_i);

	// next scheduler state
	always_comb begin
		next_state = state;
		case (state)
			PSA_IDLE: next_state = cycle_tick_i ? PSA_SCAN : PSA_IDLE;
			PSA_SCAN: next_state = !any_pending ? PSA_IDLE :
				(send_sched ? PSA_SEND : PSA_SCAN);
			PSA_SEND: next_state = PSA_SCAN;
			default:  next_state = PSA_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state <= PSA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// latch due set and one shared time at the cycle tick
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pending <= '0;
			tov     <= '0;
		end else if (state == PSA_IDLE && cycle_tick_i) begin
			pending <= due_mask_i;
			tov     <= time_now_i;
		end else if (send_sched) begin
			pending[cur_id] <= 1'b0;
		end
	end

	// pending acknowledgement; a new completion overrides an unsent one
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ack_pend <= 1'b0;
			ack_word <= '0;
		end else if (rx_done_i && want_ack) begin
			ack_pend <= 1'b1;
			// id, crc low, crc high, result
			ack_word <= {result, rx_info_i.crc_rx[15:8],
				rx_info_i.crc_rx[7:0], rx_info_i.id};
		end else if (send_ack) begin
			ack_pend <= 1'b0;
		end
	end

	// transmit register; write-only ids in the mask are skipped
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			tx_valid_o    <= 1'b0;
			tx_is_ack_o   <= 1'b0;
			tx_hdr_o      <= '0;
			ack_payload_o <= '0;
		end else if (send_ack) begin
			tx_valid_o    <= 1'b1;
			tx_is_ack_o   <= 1'b1;
			tx_hdr_o      <= '{id: PSA_ID_ACK, len: PSA_ACK_LEN,
				tov: tov};
			ack_payload_o <= ack_word;
		end else if (send_sched && sched_ent.rd) begin
			tx_valid_o  <= 1'b1;
			tx_is_ack_o <= 1'b0;
			// same tov for the whole cycle; ids 20-22 carry it
			tx_hdr_o    <= '{id: cur_id, len: sched_ent.len_a,
				tov: tov};
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	// status outputs
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rx_accept_o <= 1'b0;
			busy_o      <= 1'b0;
		end else begin
			rx_accept_o <= rx_done_i && (result == PSA_RES_OK);
			busy_o      <= (next_state != PSA_IDLE) || ack_pend;
		end
	end
endmodule

// [design/psa_table.sv]
// packet identifier table: direction and length per identifier
`timescale 1ns/1ns
module psa_table (
	input  wire logic [7:0] id_i,
	output psa_pkg::psa_entry_s entry_o
);
	import psa_pkg::*;

	// builds one entry
	// flags taken as int so plain 0 and 1 in the table keep their width
	function automatic psa_entry_s ent(input int r, input int w,
		input int v, input logic [7:0] a, input logic [7:0] b);
		return '{known: 1'b1, rd: (r != 0), wr: (w != 0),
			var_len: (v != 0), len_a: a, len_b: b};
	endfunction

	// unlisted identifiers such as 56, 59, 187 fall to default
	always_comb begin
		entry_o = '0;
		case (id_i)
			8'h00: entry_o = ent(1, 0, 0, 8'h04, 8'h00);
			8'h01: entry_o = ent(0, 1, 1, 8'h00, 8'h00);
			8'h02: entry_o = ent(1, 1, 0, 8'h01, 8'h00);
			8'h03: entry_o = ent(1, 0, 0, 8'h18, 8'h00);
			8'h04, 8'h05: entry_o = ent(0, 1, 0, 8'h04, 8'h00);
			8'h0A: entry_o = ent(1, 1, 1, 8'h00, 8'h00);
			// state packets, read only
			8'h14: entry_o = ent(1, 0, 0, 8'h64, 8'h00);
			8'h15: entry_o = ent(1, 0, 0, 8'h08, 8'h00);
			8'h16: entry_o = ent(1, 0, 0, 8'h0E, 8'h00);
			8'h17: entry_o = ent(1, 0, 0, 8'h04, 8'h00);
			8'h18, 8'h19, 8'h1A: entry_o = ent(1, 0, 0, 8'h0C, 8'h00);
			8'h1B: entry_o = ent(1, 0, 0, 8'h10, 8'h00);
			8'h1C: entry_o = ent(1, 0, 0, 8'h30, 8'h00);
			8'h1D: entry_o = ent(1, 0, 0, 8'h4A, 8'h00);
			8'h1E: entry_o = ent(1, 0, 0, 8'h0D, 8'h00);
			8'h1F: entry_o = ent(1, 0, 1, 8'h00, 8'h00);
			8'h20, 8'h21: entry_o = ent(1, 0, 0, 8'h18, 8'h00);
			8'h22: entry_o = ent(1, 0, 0, 8'h19, 8'h00);
			8'h23, 8'h24, 8'h25: entry_o = ent(1, 0, 0, 8'h0C, 8'h00);
			8'h26: entry_o = ent(1, 0, 0, 8'h10, 8'h00);
			8'h27: entry_o = ent(1, 0, 0, 8'h0C, 8'h00);
			8'h28: entry_o = ent(1, 0, 0, 8'h10, 8'h00);
			8'h29: entry_o = ent(1, 0, 0, 8'h24, 8'h00);
			8'h2A, 8'h2B: entry_o = ent(1, 0, 0, 8'h0C, 8'h00);
			// external aiding, both ways
			8'h2C: entry_o = ent(1, 1, 0, 8'h3C, 8'h00);
			8'h2D: entry_o = ent(1, 1, 0, 8'h24, 8'h00);
			8'h2E: entry_o = ent(1, 1, 0, 8'h18, 8'h00);
			8'h2F: entry_o = ent(1, 1, 0, 8'h10, 8'h18);
			8'h30: entry_o = ent(1, 1, 0, 8'h08, 8'h00);
			// write-only inputs
			8'h43: entry_o = ent(0, 1, 0, 8'h0D, 8'h00);
			8'h53: entry_o = ent(0, 1, 0, 8'h08, 8'h00);
			// defined ids past the aiding range still decode
			8'h31, 8'h34: entry_o = ent(1, 0, 0, 8'h08, 8'h00);
			8'h32: entry_o = ent(1, 0, 0, 8'h0C, 8'h00);
			8'h33: entry_o = ent(1, 0, 0, 8'h14, 8'h00);
			8'h35: entry_o = ent(1, 1, 0, 8'h08, 8'h00);
			8'h36: entry_o = ent(1, 0, 0, 8'h04, 8'h00);
			8'h39: entry_o = ent(1, 1, 0, 8'h0C, 8'h00);
			8'h3A: entry_o = ent(1, 0, 0, 8'h10, 8'h00);
			8'h44: entry_o = ent(1, 1, 0, 8'h19, 8'h00);
			8'h48: entry_o = ent(1, 1, 0, 8'h08, 8'h00);
			8'h49: entry_o = ent(1, 0, 0, 8'h18, 8'h00);
			// configuration
			8'hB4: entry_o = ent(1, 1, 0, 8'h04, 8'h00);
			8'hB5: entry_o = ent(1, 1, 1, 8'h00, 8'h00);
			8'hB6: entry_o = ent(1, 1, 0, 8'h11, 8'h00);
			// magnetic and alignment
			8'hBE: entry_o = ent(0, 1, 0, 8'h01, 8'h00);
			8'hBF: entry_o = ent(1, 0, 0, 8'h03, 8'h00);
			8'hC1: entry_o = ent(0, 1, 0, 8'h05, 8'h00);
			// remaining configuration ids, all read/write
			8'hB9: entry_o = ent(1, 1, 0, 8'h49, 8'h00);
			8'hBA: entry_o = ent(1, 1, 0, 8'h11, 8'h00);
			8'hBC: entry_o = ent(1, 1, 0, 8'h0D, 8'h00);
			8'hBD, 8'hC2: entry_o = ent(1, 1, 0, 8'h31, 8'h00);
			8'hC0: entry_o = ent(1, 1, 0, 8'h08, 8'h00);
			8'hC3: entry_o = ent(1, 1, 0, 8'h21, 8'h00);
			8'hC6: entry_o = ent(1, 1, 0, 8'h40, 8'h00);
			8'hC7: entry_o = ent(1, 1, 0, 8'h41, 8'h00);
			default: entry_o = '0;
		endcase
	end
endmodule

// [pkg/psa_pkg.sv]
// package: packet table constants, result codes, carrier structs
package psa_pkg;

	// packet identifiers with special handling
	localparam logic [7:0] PSA_ID_ACK       = 8'h00;
	localparam logic [7:0] PSA_ID_STATE     = 8'h14;
	localparam logic [7:0] PSA_ID_UNIX      = 8'h15;
	localparam logic [7:0] PSA_ID_FMT_TIME  = 8'h16;
	localparam logic [7:0] PSA_ID_AID_FIRST = 8'h2C;
	localparam logic [7:0] PSA_ID_AID_LAST  = 8'h30;
	localparam logic [7:0] PSA_ID_CFG_FIRST = 8'hB4;

	// acknowledgement layout
	localparam logic [7:0] PSA_ACK_LEN      = 8'h04;
	localparam int         PSA_ACK_BYTES    = 4;

	// crc preset and polynomial
	localparam logic [15:0] PSA_CRC_PRESET  = 16'hFFFF;
	localparam logic [15:0] PSA_CRC_POLY    = 16'h1021;

	// result codes
	localparam logic [7:0] PSA_RES_OK       = 8'h00;
	localparam logic [7:0] PSA_RES_CRC      = 8'h01;
	localparam logic [7:0] PSA_RES_SIZE     = 8'h02;
	localparam logic [7:0] PSA_RES_RANGE    = 8'h03;
	localparam logic [7:0] PSA_RES_FLASH    = 8'h04;
	localparam logic [7:0] PSA_RES_NOTRDY   = 8'h05;
	localparam logic [7:0] PSA_RES_UNKNOWN  = 8'h06;

	// length marker meaning variable length
	localparam logic [7:0] PSA_LEN_VAR      = 8'h00;

	// table entry for one identifier
	typedef struct packed {
		logic       known;    // identifier supported
		logic       rd;       // may be produced as output
		logic       wr;       // may be accepted as input
		logic       var_len;  // any length accepted
		logic [7:0] len_a;    // fixed length
		logic [7:0] len_b;    // second permitted length, 0 if none
	} psa_entry_s;

	// received packet summary from the framer
	typedef struct packed {
		logic [7:0]  id;
		logic [7:0]  len;
		logic [15:0] crc_rx;    // crc carried in the header
		logic        range_err; // field check from payload owner
		logic        flash_err; // nonvolatile store failed
		logic        not_ready; // device not able to process
	} psa_rx_s;

	// outgoing packet header for the transmit path
	typedef struct packed {
		logic [7:0]  id;
		logic [7:0]  len;
		logic [31:0] tov;       // common time of validity tag
	} psa_tx_s;

endpackage

// [testbench/packet_scheduler_ack_responder_tb.sv]
// testbench: output cycles and packet answers against a reference
`timescale 1ns/1ns
module packet_scheduler_ack_responder_tb;
	import psa_pkg::*;
	logic ref_clk_i, reset_i, rx_start_i, rx_byte_valid_i, rx_done_i;
	logic [7:0] rx_byte_i;
	psa_rx_s rx_info_i;
	logic cycle_tick_i, tx_ready_i, tx_valid_o, tx_is_ack_o;
	logic rx_accept_o, busy_o;
	logic [255:0] due_mask_i;
	logic [31:0] time_now_i, ack_payload_o;
	psa_tx_s tx_hdr_o;
	int miscompares, num_checks;
	int cycles = 0;
	logic [31:0] last_tov = '0; // time latched at the latest cycle tick
	// pool in ascending id order; length 0 marks write-only
	byte unsigned pid[12] = '{1,3,20,21,22,27,35,44,67,180,190,191};
	byte unsigned plen[12] = '{0,24,100,8,14,16,12,60,0,4,0,3};
	// packet cases: id, length, fault (1 crc 2 busy 3 range 4 store)
	int cid[21] = '{180,182,56,3,191,47,47,190,67,83,2,193,188,186,
		187,1,10,4,5,181,185};
	int clen[21] = '{4,16,4,24,3,24,20,1,13,8,1,5,13,17,1,3,7,4,4,9,73};
	int cerr[21] = '{0,0,0,0,0,0,0,0,0,0,1,2,3,4,0,0,0,0,0,0,0};
	psa_sched_ack u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.rx_start_i(rx_start_i), .rx_byte_valid_i(rx_byte_valid_i),
		.rx_byte_i(rx_byte_i), .rx_done_i(rx_done_i),
		.rx_info_i(rx_info_i), .cycle_tick_i(cycle_tick_i),
		.due_mask_i(due_mask_i), .time_now_i(time_now_i),
		.tx_ready_i(tx_ready_i), .tx_hdr_o(tx_hdr_o),
		.tx_valid_o(tx_valid_o), .tx_is_ack_o(tx_is_ack_o),
		.ack_payload_o(ack_payload_o), .rx_accept_o(rx_accept_o),
		.busy_o(busy_o));
	psa_host_model u_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.tx_valid_i(tx_valid_o), .tx_hdr_i(tx_hdr_o),
		.tx_is_ack_i(tx_is_ack_o), .ack_payload_i(ack_payload_o),
		.tx_ready_o(tx_ready_i));
	// writable length per id: -1 unsupported, 0 any length
	function automatic int wr_len(input int id);
		case (id)
			1, 10, 181: return 0;
			2, 190: return 1;
			4, 5, 180: return 4;
			193: return 5;
			48, 53, 72, 83, 192: return 8;
			57: return 12;
			67, 188: return 13;
			47: return 16;
			182, 186: return 17;
			46: return 24;
			68: return 25;
			195: return 33;
			45: return 36;
			189, 194: return 49;
			44: return 60;
			198: return 64;
			199: return 65;
			185: return 73;
			default: return -1;
		endcase
	endfunction
	task automatic chk(input logic [80:0] got, input logic [80:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded wait for the host to log n beats
	task automatic wait_beats(input int n);
		for (int i = 0; i < 120 && u_host.beats.size() < n; i++)
			@(posedge ref_clk_i);
	endtask
	// one output cycle with the picked pool ids due
	task automatic run_cycle(input logic [11:0] pick);
		logic [80:0] got;
		logic [255:0] m;
		logic [31:0] t;
		int n;
		n = 0;
		m = '0;
		t = $urandom;
		for (int k = 0; k < 12; k++) begin
			m[pid[k]] = pick[k];
			n += int'(pick[k] && plen[k] != 0);
		end
		for (int i = 0; i < 300 && (busy_o !== 1'b0 || tx_valid_o !== 1'b0); i++)
			@(posedge ref_clk_i);
		cycle_tick_i <= 1'b1;
		due_mask_i <= m;
		time_now_i <= t;
		@(posedge ref_clk_i);
		cycle_tick_i <= 1'b0;
		time_now_i <= ~t; // a late sample would show
		last_tov = t;
		@(negedge ref_clk_i);
		chk(81'(busy_o), 81'(1));
		wait_beats(n);
		chk(81'(u_host.beats.size()), 81'(n));
		for (int k = 0; k < 12; k++)
			if (pick[k] && plen[k] != 0 && u_host.beats.size() > 0) begin
				got = u_host.beats.pop_front();
				chk(81'(got[80:32]), 81'({1'b0, pid[k], plen[k], t}));
			end
	endtask
	// receive one packet and check the answer
	task automatic send_pkt(input int id, input int len, input int err);
		logic [80:0] got;
		logic [15:0] crc;
		logic [7:0] b;
		int fl;
		int res;
		crc = PSA_CRC_PRESET;
		rx_start_i <= 1'b1;
		for (int i = 0; i < len; i++) begin
			@(posedge ref_clk_i);
			b = 8'($urandom);
			rx_start_i <= 1'b0;
			rx_byte_valid_i <= 1'b1;
			rx_byte_i <= b;
			crc = crc ^ {b, 8'h00};
			for (int k = 0; k < 8; k++)
				crc = crc[15] ? (crc << 1) ^ PSA_CRC_POLY : crc << 1;
		end
		@(posedge ref_clk_i);
		rx_byte_valid_i <= 1'b0;
		crc = crc ^ 16'(err == 1);
		@(posedge ref_clk_i);
		rx_done_i <= 1'b1;
		rx_info_i <= '{id: 8'(id), len: 8'(len), crc_rx: crc,
			range_err: err == 3, flash_err: err == 4, not_ready: err == 2};
		fl = wr_len(id);
		if (fl < 0)
			res = 6;
		else if (err == 1)
			res = 1;
		else if (fl > 0 && len != fl && !(id == 47 && len == 24))
			res = 2;
		else if (err == 2)
			res = 5;
		else
			res = err == 3 ? 3 : (err == 4 ? 4 : 0);
		@(posedge ref_clk_i);
		rx_done_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(81'(rx_accept_o), 81'(res == 0));
		wait_beats(1);
		if (id >= 44 && id <= 48 && res == 0)
			chk(81'(u_host.beats.size()), 81'(0));
		else begin
			got = u_host.beats.pop_front();
			chk(got, {1'b1, 8'h00, 8'h04, last_tov, 8'(res), crc, 8'(id)});
		end
	endtask
	// clock at 125 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// main sequence
	initial begin
		reset_i = 1'b1;
		{rx_start_i, rx_byte_valid_i, rx_done_i, cycle_tick_i} = 4'h0;
		rx_byte_i = 8'h00;
		rx_info_i = '0;
		due_mask_i = '0;
		time_now_i = 32'h0;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(32'hFC12B968));
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		@(posedge ref_clk_i);
		run_cycle(12'hFF4);
		run_cycle(12'hFFF);
		repeat (6) run_cycle(12'($urandom));
		$display("scheduler test done");
		for (int i = 0; i < 21; i++)
			send_pkt(cid[i], clen[i], cerr[i]);
		$display("acknowledge test done");
		// reset in mid-run, then the block must work again
		reset_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		u_host.beats.delete();
		@(posedge ref_clk_i);
		run_cycle(12'h0E4);
		send_pkt(182, 17, 0);
		$display("reset test done");
		stop_test();
	end
	// hang guard
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			stop_test();
		end
	end
endmodule

// [testbench/psa_host_model.sv]
// host model: takes transmit beats with random stalls and logs them
`timescale 1ns/1ns
module psa_host_model
	import psa_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        tx_valid_i,
	input  wire psa_tx_s     tx_hdr_i,
	input  wire logic        tx_is_ack_i,
	input  wire logic [31:0] ack_payload_i,
	output logic             tx_ready_o
);
	logic [80:0] beats[$]; // {is_ack, header, ack payload}
	// log on handshake; stall one beat in four to test holding
	always @(posedge ref_clk_i) begin
		if (!reset_i && tx_valid_i && tx_ready_o)
			beats.push_back({tx_is_ack_i, tx_hdr_i, ack_payload_i});
		tx_ready_o <= !reset_i && ($urandom % 4 != 0);
	end
endmodule

// [testbench/psa_sched_ack_props.sv]
// checker: port-level properties of the scheduler and responder
`timescale 1ns/1ns
module psa_sched_ack_props
	import psa_pkg::*;
(
	input wire logic         ref_clk_i,
	input wire logic         reset_i,
	input wire logic         rx_done_i,
	input wire logic         cycle_tick_i,
	input wire logic [255:0] due_mask_i,
	input wire logic [31:0]  time_now_i,
	input wire logic         tx_ready_i,
	input wire psa_tx_s      tx_hdr_o,
	input wire logic         tx_valid_o,
	input wire logic         tx_is_ack_o,
	input wire logic [31:0]  ack_payload_o,
	input wire logic         rx_accept_o,
	input wire logic         busy_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0]  last_id;   // id of previous packet in this cycle
	logic        have_last; // a packet already went out this cycle
	logic [31:0] tick_tov;  // time sampled at the accepted tick
	// tick accepted only when idle; the bench never ticks otherwise
	wire tick_ok = cycle_tick_i && !busy_o && !tx_valid_o;
	wire beat    = tx_valid_o && tx_ready_i && !tx_is_ack_o;
	// track order and time within one output cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || tick_ok)
			have_last <= 1'b0;
		else if (beat)
			have_last <= 1'b1;
		if (beat)
			last_id <= tx_hdr_o.id;
		if (tick_ok)
			tick_tov <= time_now_i;
	end
	id_ascend_a: assert property (
		beat && have_last |-> tx_hdr_o.id > last_id)
		else $error("packet ids not ascending");
	tov_common_a: assert property (
		tx_valid_o && !tx_is_ack_o |-> tx_hdr_o.tov == tick_tov)
		else $error("time of validity differs");
	tx_hold_a: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_hdr_o))
		else $error("transmit beat dropped");
	ack_hdr_a: assert property (
		tx_valid_o && tx_is_ack_o |->
		tx_hdr_o.id == 8'h00 && tx_hdr_o.len == 8'h04)
		else $error("ack header wrong");
	result_range_a: assert property (
		tx_valid_o && tx_is_ack_o |-> ack_payload_o[31:24] <= 8'h06)
		else $error("ack result code out of range");
	accept_cause_a: assert property (rx_accept_o |-> $past(rx_done_i))
		else $error("accept without packet");
	first_pkt_a: assert property (
		tick_ok && !rx_done_i && due_mask_i[20] &&
		due_mask_i[19:0] == 20'h0 |->
		##2 tx_valid_o && tx_hdr_o.id == 8'h14)
		else $error("first packet late or wrong");
	reset_quiet_a: assert property (
		$past(reset_i) |-> !tx_valid_o && !rx_accept_o)
		else $error("output active after reset");
endmodule
bind psa_sched_ack psa_sched_ack_props u_props (
	.ref_clk_i     (ref_clk_i),
	.reset_i       (reset_i),
	.rx_done_i     (rx_done_i),
	.cycle_tick_i  (cycle_tick_i),
	.due_mask_i    (due_mask_i),
	.time_now_i    (time_now_i),
	.tx_ready_i    (tx_ready_i),
	.tx_hdr_o      (tx_hdr_o),
	.tx_valid_o    (tx_valid_o),
	.tx_is_ack_o   (tx_is_ack_o),
	.ack_payload_o (ack_payload_o),
	.rx_accept_o   (rx_accept_o),
	.busy_o        (busy_o)
);
